//--- nbh_pkg.sv
package nbh_pkg;
    // array timing, figures in microseconds or nanoseconds as printed
    localparam int CLK_MHZ        = 50;
    localparam int CLK_NS         = 20;
    localparam int READ_MAX_US    = 25;
    localparam int PROG_MAX_US    = 900;
    localparam int ERASE_MAX_US   = 16000;
    localparam int RST_MAX_US     = 500;
    localparam int WB_MAX_NS      = 100;
    localparam int ADL_MIN_NS     = 70;
    localparam int WHR_MIN_NS     = 60;
    localparam int NOP_MAX        = 4;
    localparam int READ_TO_CYC    = READ_MAX_US * CLK_MHZ;
    localparam int WB_CYC         = (WB_MAX_NS + CLK_NS - 1) / CLK_NS;
    localparam int ADL_CYC        = (ADL_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int WHR_CYC        = (WHR_MIN_NS + CLK_NS - 1) / CLK_NS;
    // array geometry
    localparam logic [11:0] MARK_COL   = 12'h800;
    localparam logic [7:0]  ERASED     = 8'hff;
    localparam int          PAGE_BITS  = 6;
    // command bytes
    localparam logic [7:0] C_READ1  = 8'h00;
    localparam logic [7:0] C_READ2  = 8'h30;
    localparam logic [7:0] C_PROG1  = 8'h80;
    localparam logic [7:0] C_PROG2  = 8'h10;
    localparam logic [7:0] C_ERASE1 = 8'h60;
    localparam logic [7:0] C_ERASE2 = 8'hd0;
    localparam logic [7:0] C_STATUS = 8'h70;
    localparam logic [7:0] C_RESET  = 8'hff;

    typedef enum logic [2:0] {
        OP_READ  = 3'h0,
        OP_PROG  = 3'h1,
        OP_ERASE = 3'h2,
        OP_RESET = 3'h3,
        OP_SCAN  = 3'h4
    } nbh_op_type;

    typedef enum logic [2:0] {
        ER_OK      = 3'h0,
        ER_TIMEOUT = 3'h1,
        ER_FAIL    = 3'h2,
        ER_BAD     = 3'h3,
        ER_NOP     = 3'h4,
        ER_MARKED  = 3'h5
    } nbh_err_type;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_CMD   = 4'h1,
        ST_ADDR  = 4'h3,
        ST_WDATA = 4'h2,
        ST_CMD2  = 4'h6,
        ST_BUSY  = 4'h7,
        ST_STCMD = 4'h5,
        ST_STRD  = 4'h4,
        ST_RDATA = 4'hc,
        ST_DONE  = 4'hd
    } nbh_state_type;
endpackage : nbh_pkg

//--- nbh_host.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - host refuses a fifth back-to-back partial program to one page before erase
// - host scans page 0 and, if unmarked, page 1, builds table, never erases bad marks
// - host keeps every read, program and erase away from blocks marked invalid
// - status read after each program or erase that leaves busy before timeout; failure retires block
// - on program failure user copies pages 1..n-1 then page n
// - replaced block recorded invalid and never programmed or erased
// - read data goes out raw for the user's ECC stage
module nbh_host import nbh_pkg::*; #(
    parameter int NUM_BLOCKS    = 4096,
    parameter int PROG_TO_CYC   = PROG_MAX_US * CLK_MHZ,
    parameter int ERASE_TO_CYC  = ERASE_MAX_US * CLK_MHZ,
    parameter int RST_TO_CYC    = RST_MAX_US * CLK_MHZ
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        cmd_valid,
    input  wire logic [2:0]  cmd_op,
    input  wire logic [17:0] cmd_row,
    input  wire logic [11:0] cmd_col,
    input  wire logic [11:0] cmd_len,
    output logic             cmd_ready,
    input  wire logic        wr_valid,
    input  wire logic [7:0]  wr_data,
    output logic             wr_ready,
    output logic             rd_valid,
    output logic [7:0]       rd_data,
    output logic             done,
    output logic [2:0]       err,
    output logic             nand_ce_n,
    output logic             nand_cle,
    output logic             nand_ale,
    output logic             nand_we_n,
    output logic             nand_re_n,
    output logic             nand_wp_n,
    output logic [7:0]       nand_dq_out,
    output logic             nand_dq_oe,
    input  wire logic [7:0]  nand_dq_in,
    input  wire logic        nand_ready
);
    localparam int BLK_BITS = 18 - PAGE_BITS;
    generate
        if (NUM_BLOCKS > 2**BLK_BITS || ERASE_TO_CYC >= 2**20)
            $error("nbh_host: parameters exceed counter or table width");
    endgenerate

    function automatic logic [7:0] addr_byte(input logic [11:0] c,
                                             input logic [17:0] r,
                                             input logic [2:0]  i);
        case (i)
            3'h0:    addr_byte = c[7:0];
            3'h1:    addr_byte = {4'h0, c[11:8]};
            3'h2:    addr_byte = r[7:0];
            3'h3:    addr_byte = r[15:8];
            default: addr_byte = {6'h00, r[17:16]};
        endcase
    endfunction

    logic rst_s1, rst_s2;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end
    wire logic rst_n = rst_s2;

    nbh_state_type          state, next_state;
    nbh_op_type             op, next_op;
    logic [17:0]            row, next_row;
    logic [11:0]            col, next_col, len, next_len, cnt, next_cnt;
    logic [1:0]             ph, next_ph;
    logic [2:0]             idx, next_idx;
    logic [19:0]            tout, next_tout;
    logic [3:0]             tmr, next_tmr;
    logic [NUM_BLOCKS-1:0]  bad, next_bad;
    logic [17:0]            last_row, next_last_row;
    logic [2:0]             nop, next_nop;
    logic                   next_cmd_ready, next_wr_ready, next_rd_valid;
    logic                   next_done, next_ce_n, next_cle, next_ale;
    logic                   next_we_n, next_re_n, next_dq_oe;
    logic [7:0]             next_rd_data, next_dq_out;
    logic [2:0]             next_err;
    logic [19:0]            limit;
    logic [BLK_BITS-1:0]    blk;
    logic                   slot_end;

    assign blk = row[17:PAGE_BITS];

    always_comb begin
        next_state = state;      next_op = op;       next_row = row;
        next_col = col;          next_len = len;     next_cnt = cnt;
        next_ph = ph;            next_idx = idx;     next_tout = tout;
        next_tmr = tmr;          next_bad = bad;     next_last_row = last_row;
        next_nop = nop;          next_err = err;     next_rd_data = rd_data;
        next_rd_valid = 1'b0;    next_done = 1'b0;   next_cle = 1'b0;
        next_ale = 1'b0;         next_we_n = 1'b1;   next_re_n = 1'b1;
        next_dq_oe = 1'b0;       next_dq_out = nand_dq_out;
        slot_end = (ph == 2'h3);
        case (op)
            OP_PROG:  limit = 20'(PROG_TO_CYC);
            OP_ERASE: limit = 20'(ERASE_TO_CYC);
            OP_RESET: limit = 20'(RST_TO_CYC);
            default:  limit = 20'(READ_TO_CYC);
        endcase
        case (state)
            ST_IDLE: begin
                if (cmd_valid && cmd_ready) begin
                    next_op = nbh_op_type'(cmd_op);
                    next_row = cmd_row;
                    next_col = cmd_col;
                    next_len = cmd_len;
                    next_cnt = 12'h000;
                    next_ph = 2'h0;
                    next_err = ER_OK;
                    next_state = ST_CMD;
                    if (cmd_op == OP_SCAN) begin
                        next_col = MARK_COL;
                        next_len = 12'h001;
                        next_row = {cmd_row[17:PAGE_BITS], {PAGE_BITS{1'b0}}};
                    end else if (cmd_op != OP_RESET &&
                                 bad[cmd_row[17:PAGE_BITS]]) begin
                        next_err = ER_BAD;
                        next_state = ST_DONE;
                    end else if (cmd_op == OP_PROG) begin
                        if (cmd_row == last_row && nop == 3'(NOP_MAX)) begin
                            next_err = ER_NOP;
                            next_state = ST_DONE;
                        end else begin
                            next_nop = (cmd_row == last_row) ? nop + 3'h1
                                                             : 3'h1;
                            next_last_row = cmd_row;
                        end
                    end else if (cmd_op == OP_ERASE &&
                                 cmd_row[17:PAGE_BITS] ==
                                 last_row[17:PAGE_BITS]) begin
                        next_nop = 3'h0;
                    end
                end
            end
            ST_CMD, ST_CMD2, ST_STCMD: begin
                next_cle = 1'b1;
                next_dq_oe = 1'b1;
                next_we_n = ph[1];
                if (state == ST_STCMD)
                    next_dq_out = C_STATUS;
                else case (op)
                    OP_PROG:  next_dq_out = state == ST_CMD ? C_PROG1 : C_PROG2;
                    OP_ERASE: next_dq_out = state == ST_CMD ? C_ERASE1 : C_ERASE2;
                    OP_RESET: next_dq_out = C_RESET;
                    default:  next_dq_out = state == ST_CMD ? C_READ1 : C_READ2;
                endcase
                next_ph = ph + 2'h1;
                if (slot_end) begin
                    next_tmr = 4'(WB_CYC);
                    next_tout = 20'h00000;
                    if (state == ST_STCMD) begin
                        next_tmr = 4'(WHR_CYC);
                        next_state = ST_STRD;
                    end else if (state == ST_CMD2 || op == OP_RESET)
                        next_state = ST_BUSY;
                    else begin
                        next_idx = (op == OP_ERASE) ? 3'h2 : 3'h0;
                        next_state = ST_ADDR;
                    end
                end
            end
            ST_ADDR: begin
                next_ale = 1'b1;
                next_dq_oe = 1'b1;
                next_we_n = ph[1];
                next_dq_out = addr_byte(col, row, idx);
                next_ph = ph + 2'h1;
                if (slot_end) begin
                    next_idx = idx + 3'h1;
                    next_tmr = 4'(ADL_CYC);
                    if (idx == 3'h4)
                        next_state = (op == OP_PROG) ? ST_WDATA : ST_CMD2;
                end
            end
            ST_WDATA: begin
                next_dq_oe = 1'b1;
                if (tmr != 4'h0)
                    next_tmr = tmr - 4'h1;
                else if (ph != 2'h0 || (wr_valid && wr_ready)) begin
                    if (ph == 2'h0)
                        next_dq_out = wr_data;
                    next_we_n = ph[1];
                    next_ph = ph + 2'h1;
                    if (slot_end) begin
                        next_cnt = cnt + 12'h001;
                        if (cnt == len - 12'h001)
                            next_state = ST_CMD2;
                    end
                end
            end
            ST_BUSY: begin
                next_tout = tout + 20'h00001;
                next_ph = 2'h0;
                if (tmr != 4'h0)
                    next_tmr = tmr - 4'h1;
                else if (nand_ready) begin
                    next_cnt = 12'h000;
                    if (op == OP_PROG || op == OP_ERASE)
                        next_state = ST_STCMD;
                    else if (op == OP_RESET)
                        next_state = ST_DONE;
                    else
                        next_state = ST_RDATA;
                end else if (tout >= limit) begin
                    next_err = ER_TIMEOUT;
                    next_state = ST_DONE;
                end
            end
            ST_STRD, ST_RDATA: begin
                if (tmr != 4'h0)
                    next_tmr = tmr - 4'h1;
                else begin
                    next_re_n = ph[1];
                    next_ph = ph + 2'h1;
                    if (ph == 2'h1) begin
                        next_rd_data = nand_dq_in;
                        next_rd_valid = (state == ST_RDATA && op == OP_READ);
                        if (state == ST_STRD && nand_dq_in[0]) begin
                            next_err = ER_FAIL;
                            next_bad[blk] = 1'b1;
                        end
                        if (op == OP_SCAN && nand_dq_in != ERASED) begin
                            next_err = ER_MARKED;
                            next_bad[blk] = 1'b1;
                        end
                    end
                    if (slot_end) begin
                        next_cnt = cnt + 12'h001;
                        if (state == ST_STRD || cnt == len - 12'h001) begin
                            next_state = ST_DONE;
                            if (op == OP_SCAN && err == ER_OK && !row[0]) begin
                                next_row = row + 18'h00001;
                                next_ph = 2'h0;
                                next_state = ST_CMD;
                            end
                        end
                    end
                end
            end
            ST_DONE: begin
                next_done = 1'b1;
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
        next_ce_n = (next_state == ST_IDLE || next_state == ST_DONE);
        next_cmd_ready = (next_state == ST_IDLE);
        next_wr_ready = (next_state == ST_WDATA && next_ph == 2'h0 &&
                         next_tmr == 4'h0 && !(wr_valid && wr_ready));
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;     op <= OP_READ;      row <= 18'h00000;
            col <= 12'h000;       len <= 12'h000;     cnt <= 12'h000;
            ph <= 2'h0;           idx <= 3'h0;        tout <= 20'h00000;
            tmr <= 4'h0;          bad <= '0;          last_row <= 18'h3ffff;
            nop <= 3'h0;          err <= ER_OK;       rd_data <= 8'h00;
            rd_valid <= 1'b0;     done <= 1'b0;       cmd_ready <= 1'b0;
            wr_ready <= 1'b0;     nand_ce_n <= 1'b1;  nand_cle <= 1'b0;
            nand_ale <= 1'b0;     nand_we_n <= 1'b1;  nand_re_n <= 1'b1;
            nand_wp_n <= 1'b0;    nand_dq_out <= 8'h00;
            nand_dq_oe <= 1'b0;
        end else begin
            state <= next_state;  op <= next_op;      row <= next_row;
            col <= next_col;      len <= next_len;    cnt <= next_cnt;
            ph <= next_ph;        idx <= next_idx;    tout <= next_tout;
            tmr <= next_tmr;      bad <= next_bad;    last_row <= next_last_row;
            nop <= next_nop;      err <= next_err;    rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;   done <= next_done;
            cmd_ready <= next_cmd_ready; wr_ready <= next_wr_ready;
            nand_ce_n <= next_ce_n;      nand_cle <= next_cle;
            nand_ale <= next_ale;        nand_we_n <= next_we_n;
            nand_re_n <= next_re_n;      nand_wp_n <= 1'b1;
            nand_dq_out <= next_dq_out;  nand_dq_oe <= next_dq_oe;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    read_wait_bound_a: assert property (state == ST_BUSY &&
        op == OP_READ |-> tout <= 20'(READ_TO_CYC) + 20'h00001)
        else $error("read busy wait overran its limit");
    prog_timeout_a: assert property (state == ST_BUSY &&
        op == OP_PROG && tmr == 4'h0 && !nand_ready &&
        tout >= 20'(PROG_TO_CYC) |=> state == ST_DONE ##1 done &&
        err == ER_TIMEOUT)
        else $error("program timeout not reported");
    reset_timeout_a: assert property (state == ST_BUSY &&
        op == OP_RESET |-> tout <= 20'(RST_TO_CYC) + 20'h00001)
        else $error("reset busy wait overran its limit");
    nop_refuse_a: assert property (state == ST_IDLE && cmd_valid &&
        cmd_ready && cmd_op == OP_PROG && cmd_row == last_row &&
        nop == 3'(NOP_MAX) && !bad[cmd_row[17:PAGE_BITS]]
        |=> ##1 done && err == ER_NOP)
        else $error("fifth partial program not refused");
    bad_guard_a: assert property (state == ST_CMD && op != OP_SCAN &&
        op != OP_RESET |-> !bad[blk])
        else $error("command issued to a block marked bad");
    status_after_a: assert property (state == ST_BUSY &&
        tmr == 4'h0 && nand_ready && (op == OP_PROG || op == OP_ERASE)
        |=> state == ST_STCMD ##1 nand_cle && nand_dq_out == C_STATUS)
        else $error("status not read after program or erase");
    fail_retire_a: assert property (state == ST_STRD &&
        tmr == 4'h0 && ph == 2'h1 && nand_dq_in[0] |=> bad[blk] ##3 done)
        else $error("failed block not retired");
    scan_mark_a: assert property (state == ST_ADDR && op == OP_SCAN
        |-> col == MARK_COL && row[PAGE_BITS-1:1] == '0)
        else $error("scan reads the wrong marking location");
    // strobe stays low two clocks, then high at least two
    we_pulse_a: assert property ($fell(nand_we_n) |->
        !nand_we_n ##1 !nand_we_n ##1 nand_we_n ##1 nand_we_n)
        else $error("write strobe shape broken");

    prog_pass_c: cover property (state == ST_STRD ##[1:20]
        done && err == ER_OK);
    prog_fail_c: cover property (done && err == ER_FAIL);
    scan_mark_c: cover property (done && err == ER_MARKED);
    timeout_c:   cover property (done && err == ER_TIMEOUT);
endmodule : nbh_host
`default_nettype wire

//--- nbh_nand_model.sv
`timescale 1ns/100ps
`default_nettype none
module nbh_nand_model #(
    parameter logic [11:0] BAD_BLK  = 12'h005,
    parameter logic [11:0] FAIL_BLK = 12'h009,
    parameter int          READ_NS  = 2000,
    parameter int          PROG_NS  = 4000,
    parameter int          ERASE_NS = 3000,
    parameter int          RST_NS   = 1000,
    parameter int          STALL_NS = 30000
) (
    input  wire logic       ce_n,
    input  wire logic       cle,
    input  wire logic       ale,
    input  wire logic       we_n,
    input  wire logic       re_n,
    input  wire logic [7:0] dq,
    input  wire logic       stall,
    output logic [7:0]      dq_dev,
    output logic            ready,
    output logic [7:0]      viol
);
    logic [7:0]  mem [logic [29:0]];
    int          nop [logic [17:0]];
    logic        retired [logic [11:0]];
    logic [7:0]  a [5];
    logic [7:0]  cmd;
    logic [7:0]  q;
    logic [17:0] row;
    logic [11:0] col;
    logic        fail;
    int          n;
    logic [29:0] dead [$];

    initial begin
        ready = 1'b1;
        viol = 8'h00;
        q = 8'h00;
        cmd = 8'h00;
        fail = 1'b0;
        n = 0;
        mem[{BAD_BLK, 6'h01, 12'h800}] = 8'h00; // marked on page 1
    end
    // a released bus shows the inverse, never a stale copy
    assign dq_dev = (!ce_n && !re_n) ? q : ~q;

    task automatic go_busy(input int t);
        ready <= #40 1'b0;
        ready <= #(40 + (stall ? STALL_NS : t)) 1'b1;
    endtask

    // latched mid-pulse so same-edge updates of the host have landed
    always @(negedge we_n) begin
        #10;
        if (!ce_n && cle) begin
            if (!ready && dq != 8'h70) viol = viol + 8'h01;
            cmd = dq;
            n = 0;
            case (dq)
                8'h30: go_busy(READ_NS);
                8'h10: begin
                    nop[row] = nop.exists(row) ? nop[row] + 1 : 1;
                    if (nop[row] > 4) viol = viol + 8'h01;
                    if (row[17:6] == BAD_BLK || retired.exists(row[17:6]))
                        viol = viol + 8'h01;
                    fail = (row[17:6] == FAIL_BLK);
                    if (fail) retired[row[17:6]] = 1'b1;
                    go_busy(PROG_NS);
                end
                8'hd0: begin
                    row = {a[2][1:0], a[1], a[0]};
                    if (row[17:6] == BAD_BLK || retired.exists(row[17:6]))
                        viol = viol + 8'h01;
                    dead.delete();
                    foreach (mem[k]) if (k[29:18] == row[17:6]) dead.push_back(k);
                    foreach (dead[i]) mem.delete(dead[i]);
                    foreach (nop[r]) if (r[17:6] == row[17:6]) nop[r] = 0;
                    fail = 1'b0;
                    go_busy(ERASE_NS);
                end
                8'hff: go_busy(RST_NS);
                // host is single-plane, so no dummy busy may arise
                8'h11, 8'h81: viol = viol + 8'h01;
                default: ;
            endcase
        end else if (!ce_n && ale) begin
            a[n] = dq;
            n = n + 1;
            if (n == 5) begin
                row = {a[4][1:0], a[3], a[2]};
                col = {a[1][3:0], a[0]};
            end
        end else if (!ce_n) begin
            mem[{row, col}] = dq;
            col = col + 12'h001;
        end
    end

    always @(negedge re_n) begin
        if (cmd == 8'h70) q = {1'b1, ready, 5'h00, fail};
        else begin
            q = mem.exists({row, col}) ? mem[{row, col}] : 8'hff;
            col = col + 12'h001;
        end
    end
endmodule : nbh_nand_model
`default_nettype wire

//--- nbh_host_tb.sv
`timescale 1ns/100ps
`default_nettype none
module nbh_host_tb import nbh_pkg::*;;
    localparam logic [11:0] BAD = 12'h005;
    localparam logic [11:0] FLB = 12'h009;
    localparam logic [17:0] ROW_A = {12'h000, 6'h03};
    logic core_clk, arst_n, cmd_valid, cmd_ready, wr_valid, wr_ready;
    logic rd_valid, done, ce_n, cle, ale, we_n, re_n, wp_n, dq_oe;
    logic ready, stall;
    logic [2:0] cmd_op, err;
    logic [17:0] cmd_row;
    logic [11:0] cmd_col, cmd_len;
    logic [7:0] wr_data, rd_data, dq_out, dev_dq, dq_bus, viol;
    logic [7:0] wq [$];
    logic [7:0] rq [$];
    int n_mismatch = 0;
    int check_count = 0;

    assign dq_bus = (dq_oe === 1'b1) ? dq_out : dev_dq;

    nbh_host #(.PROG_TO_CYC(400), .ERASE_TO_CYC(400), .RST_TO_CYC(100)) dut (
        .core_clk(core_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_row(cmd_row), .cmd_col(cmd_col),
        .cmd_len(cmd_len), .cmd_ready(cmd_ready), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .done(done), .err(err), .nand_ce_n(ce_n),
        .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n),
        .nand_wp_n(wp_n), .nand_dq_out(dq_out), .nand_dq_oe(dq_oe),
        .nand_dq_in(dq_bus), .nand_ready(ready));
    // model defaults put the marked and failing blocks at BAD and FLB
    nbh_nand_model model (
        .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
        .dq(dq_bus), .stall(stall), .dq_dev(dev_dq), .ready(ready),
        .viol(viol));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        wr_valid <= (wq.size() != 0);
        wr_data <= (wq.size() != 0) ? wq[0] : 8'h00;
    end
    always @(posedge core_clk) begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1) void'(wq.pop_front());
        if (rd_valid === 1'b1) rq.push_back(rd_data);
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic run(input logic [2:0] op, input logic [17:0] row,
                       input logic [11:0] col, input logic [11:0] len,
                       input logic [2:0] exp_err);
        int k;
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_row = row;
        cmd_col = col;
        cmd_len = len;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 100) begin
            @(negedge core_clk);
            k++;
        end
        chk("cmd taken", 8'h01, {7'h00, cmd_ready});
        @(negedge core_clk);
        cmd_valid = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 20000) begin
            @(negedge core_clk);
            k++;
        end
        chk("done", 8'h01, {7'h00, done});
        chk("err", {5'h00, exp_err}, {5'h00, err});
    endtask : run

    task automatic t_scan_refuse;
        nbh_op_type ops [3] = '{OP_READ, OP_PROG, OP_ERASE};
        run(OP_RESET, 18'h00000, 12'h000, 12'h001, ER_OK);
        run(OP_SCAN, {BAD, 6'h00}, 12'h000, 12'h001, ER_MARKED);
        run(OP_SCAN, {12'h002, 6'h00}, 12'h000, 12'h001, ER_OK);
        foreach (ops[i]) run(ops[i], {BAD, 6'h02}, 12'h000, 12'h001, ER_BAD);
    endtask : t_scan_refuse

    task automatic t_prog_read;
        wq = '{8'ha5, 8'h3c};
        run(OP_PROG, ROW_A, 12'h00a, 12'h002, ER_OK);
        chk("bytes left", 8'h00, 8'(wq.size()));
        chk("write protect", 8'h01, {7'h00, wp_n});
        rq.delete();
        run(OP_READ, ROW_A, 12'h00a, 12'h003, ER_OK);
        chk("read count", 8'h03, 8'(rq.size()));
        chk("read byte0", 8'ha5, rq[0]);
        chk("read byte1", 8'h3c, rq[1]);
        chk("read byte2", 8'hff, rq[2]);
    endtask : t_prog_read

    task automatic t_nop;
        for (int i = 0; i < NOP_MAX - 1; i++) begin
            wq.push_back(8'(i));
            run(OP_PROG, ROW_A, 12'h020, 12'h001, ER_OK);
        end
        run(OP_PROG, ROW_A, 12'h020, 12'h001, ER_NOP);
        run(OP_ERASE, ROW_A, 12'h000, 12'h001, ER_OK);
        wq.push_back(8'h5a);
        run(OP_PROG, ROW_A, 12'h020, 12'h001, ER_OK);
    endtask : t_nop

    task automatic t_fail_timeout;
        wq.push_back(8'h11);
        run(OP_PROG, {FLB, 6'h04}, 12'h000, 12'h001, ER_FAIL);
        run(OP_ERASE, {FLB, 6'h00}, 12'h000, 12'h001, ER_BAD);
        run(OP_PROG, {FLB, 6'h05}, 12'h000, 12'h001, ER_BAD);
        stall = 1'b1;
        wq.push_back(8'h22);
        run(OP_PROG, {12'h003, 6'h00}, 12'h000, 12'h001, ER_TIMEOUT);
        chk("device misuse", 8'h00, viol);
    endtask : t_fail_timeout

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    initial begin
        #1000000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        arst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 3'h0;
        cmd_row = 18'h00000;
        cmd_col = 12'h000;
        cmd_len = 12'h001;
        stall = 1'b0;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        t_scan_refuse();
        t_prog_read();
        t_nop();
        t_fail_timeout();
        report_and_stop();
    end
endmodule : nbh_host_tb
`default_nettype wire
